//--- core/acap_top.sv
// Convert-start sequencing, channel mode, alert/busy pin and address select with an AHB-Lite register slave.
`timescale 1ns/1ps
`include "acap_defines.svh"
module acap_top
   import acap_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        convert_start_pin,
   input  wire logic        address_select_pin,
   input  wire logic        address_select_float,
   input  wire logic [11:0] conv_data,
   output logic             power_on,
   output logic             track_hold,
   output logic             mux_select,
   output logic             ref_from_supply,
   output logic             ref_pin_is_reference,
   input  wire logic        alert_busy_i,
   output logic             alert_busy_o,
   output logic             alert_busy_oe,
   output logic [6:0]       bus_address,
   output logic             irq
);

   acap_state_type state_q;
   acap_state_type state_d;
   logic [3:0]     ctrl_q;
   logic [11:0]    lim_low_q;
   logic [11:0]    lim_high_q;
   logic [11:0]    result_q;
   logic           result_chan_q;
   logic           result_valid_q;
   logic           result_bad_q;
   logic           pu_ok_q;
   logic           short_q;
   logic           alert_q;
   logic [2:0]     int_st_q;
   logic [2:0]     int_mask_q;
   logic           addr_taken_q;
   logic [6:0]     bus_address_q;
   logic           power_on_q;
   logic           track_hold_q;
   logic           mux_select_q;
   logic           ref_supply_q;
   logic           ref_pin_q;
   logic           oe_q;
   logic           irq_q;
   logic [31:0]    hrdata_q;
   logic           wr_pend_q;
   logic [7:0]     wr_addr_q;
   logic           rise;
   logic           fall;
   logic           pu_last;
   logic           conv_last;
   logic           start_conv;
   logic           conv_done;
   logic           range_bad;
   logic           access;
   logic           wr_en;
   logic [2:0]     int_set;
   logic [2:0]     int_clr;
   logic [31:0]    rd_mux;

   acap_edge u_edge (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .level_i (convert_start_pin),
      .rise_o  (rise),
      .fall_o  (fall)
   );

   acap_timer u_pu_timer (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .load_i  (rise),
      .value_i (`ACAP_POWERUP_CYCLES),
      .last_o  (pu_last)
   );

   acap_timer u_conv_timer (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .load_i  (start_conv),
      .value_i (`ACAP_CONV_CYCLES),
      .last_o  (conv_last)
   );

   // A falling edge with no rising edge seen first is ignored: the converter is still asleep.
   assign start_conv = fall && (state_q == ACAP_WAKE);
   assign conv_done  = (state_q == ACAP_CONV) && conv_last;
   assign range_bad  = acap_out_of_range(conv_data, lim_low_q, lim_high_q);

   // Edges arriving mid-conversion are ignored so a conversion is never cut short.
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ACAP_DOWN: begin
            if (rise) begin
               state_d = ACAP_WAKE;
            end
         end
         ACAP_WAKE: begin
            if (start_conv) begin
               state_d = ACAP_CONV;
            end
         end
         ACAP_CONV: begin
            if (conv_last) begin
               state_d = ACAP_DOWN;
            end
         end
         default: begin
            state_d = ACAP_DOWN;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_q      <= ACAP_DOWN;
         power_on_q   <= 1'b0;
         track_hold_q <= 1'b0;
      end else begin
         state_q      <= state_d;
         power_on_q   <= (state_d != ACAP_DOWN);
         track_hold_q <= (state_d == ACAP_CONV);
      end
   end

   // The power-up window restarts on every rising edge.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pu_ok_q <= 1'b0;
         short_q <= 1'b0;
      end else begin
         if (rise) begin
            pu_ok_q <= 1'b0;
         end else if (pu_last) begin
            pu_ok_q <= 1'b1;
         end
         if (start_conv) begin
            short_q <= !pu_ok_q && !pu_last;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         mux_select_q <= 1'b0;
         ref_supply_q <= 1'b1;
         ref_pin_q    <= 1'b0;
      end else begin
         ref_pin_q    <= ctrl_q[`ACAP_CTRL_MODE];
         ref_supply_q <= !ctrl_q[`ACAP_CTRL_MODE];
         if (state_q != ACAP_CONV) begin
            mux_select_q <= !ctrl_q[`ACAP_CTRL_MODE] && ctrl_q[`ACAP_CTRL_CHAN];
         end
      end
   end

   // Result, alert level and busy release all change on the same edge.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         result_q       <= 12'h000;
         result_chan_q  <= 1'b0;
         result_valid_q <= 1'b0;
         result_bad_q   <= 1'b0;
         alert_q        <= 1'b0;
      end else if (start_conv) begin
         result_valid_q <= 1'b0;
      end else if (conv_done) begin
         result_q       <= conv_data;
         result_chan_q  <= mux_select_q;
         result_valid_q <= 1'b1;
         result_bad_q   <= short_q;
         alert_q        <= range_bad;
      end
   end

   // The pin is only ever pulled low; the level comes from the external pull-up.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         oe_q <= 1'b0;
      end else if (ctrl_q[`ACAP_CTRL_BUSY_SEL]) begin
         oe_q <= (state_d == ACAP_CONV);
      end else begin
         oe_q <= ctrl_q[`ACAP_CTRL_ALERT_EN] && (conv_done ? range_bad : alert_q);
      end
   end

   // The strap is caught on the first edge after reset release, not under reset.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         addr_taken_q  <= 1'b0;
         bus_address_q <= `ACAP_ADDR_FLOAT;
      end else if (!addr_taken_q) begin
         addr_taken_q <= 1'b1;
         if (address_select_float) begin
            bus_address_q <= `ACAP_ADDR_FLOAT;
         end else if (address_select_pin) begin
            bus_address_q <= `ACAP_ADDR_HIGH;
         end else begin
            bus_address_q <= `ACAP_ADDR_LOW;
         end
      end
   end

   assign access = hsel && htrans[1] && hready;
   assign wr_en  = wr_pend_q;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end else begin
         wr_pend_q <= access && hwrite;
         if (access) begin
            wr_addr_q <= haddr[7:0];
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_q     <= `ACAP_CTRL_RESET;
         lim_low_q  <= `ACAP_LIM_LOW_RESET;
         lim_high_q <= `ACAP_LIM_HIGH_RESET;
         int_mask_q <= 3'h0;
      end else if (wr_en) begin
         unique case (wr_addr_q)
            `ACAP_OFF_CTRL: begin
               ctrl_q <= hwdata[3:0];
            end
            `ACAP_OFF_LIMITS: begin
               lim_low_q  <= hwdata[`ACAP_LIM_LOW_LSB +: 12];
               lim_high_q <= hwdata[`ACAP_LIM_HIGH_LSB +: 12];
            end
            `ACAP_OFF_INT_MASK: begin
               int_mask_q <= hwdata[2:0];
            end
            default: begin
            end
         endcase
      end
   end

   always_comb begin
      int_set                  = 3'h0;
      int_set[`ACAP_INT_DONE]  = conv_done;
      int_set[`ACAP_INT_ALERT] = conv_done && range_bad;
      int_set[`ACAP_INT_SHORT] = conv_done && short_q;
      int_clr = (wr_en && (wr_addr_q == `ACAP_OFF_INT_STATUS)) ? hwdata[2:0] : 3'h0;
   end

   // A new event in the clearing cycle survives the clear.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         int_st_q <= 3'h0;
         irq_q    <= 1'b0;
      end else begin
         int_st_q <= acap_w1c(int_st_q, int_set, int_clr);
         irq_q    <= |(acap_w1c(int_st_q, int_set, int_clr) & int_mask_q);
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (haddr[7:0])
         `ACAP_OFF_CTRL: begin
            rd_mux[3:0] = ctrl_q;
         end
         `ACAP_OFF_LIMITS: begin
            rd_mux[`ACAP_LIM_LOW_LSB +: 12]  = lim_low_q;
            rd_mux[`ACAP_LIM_HIGH_LSB +: 12] = lim_high_q;
         end
         `ACAP_OFF_RESULT: begin
            rd_mux[11:0] = result_q;
            rd_mux[12]   = result_chan_q;
            rd_mux[13]   = result_valid_q;
            rd_mux[14]   = result_bad_q;
         end
         `ACAP_OFF_STATUS: begin
            rd_mux[1:0]  = state_q;
            rd_mux[2]    = power_on_q;
            rd_mux[3]    = track_hold_q;
            rd_mux[10:4] = bus_address_q;
            rd_mux[11]   = alert_busy_i;
         end
         `ACAP_OFF_INT_STATUS: begin
            rd_mux[2:0] = int_st_q;
         end
         `ACAP_OFF_INT_MASK: begin
            rd_mux[2:0] = int_mask_q;
         end
         default: begin
         end
      endcase
   end

   // Read data is captured at the address phase so the slave never inserts wait states.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         hrdata_q <= 32'h0000_0000;
      end else if (access && !hwrite) begin
         hrdata_q <= rd_mux;
      end
   end

   assign hrdata               = hrdata_q;
   assign hreadyout            = 1'b1;
   assign hresp                = 1'b0;
   assign power_on             = power_on_q;
   assign track_hold           = track_hold_q;
   assign mux_select           = mux_select_q;
   assign ref_from_supply      = ref_supply_q;
   assign ref_pin_is_reference = ref_pin_q;
   assign alert_busy_o         = 1'b0;
   assign alert_busy_oe        = oe_q;
   assign bus_address          = bus_address_q;
   assign irq                  = irq_q;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);

   sequence s_conv_begin;
      start_conv && ctrl_q[`ACAP_CTRL_BUSY_SEL];
   endsequence

   sequence s_conv_end;
      conv_done && ctrl_q[`ACAP_CTRL_BUSY_SEL];
   endsequence

   a_rise_powers_up: assert property (
      (state_q == ACAP_DOWN) && rise |=> power_on_q && (state_q == ACAP_WAKE))
      else $error("rising edge did not power up the converter");

   a_fall_holds_conv: assert property (
      start_conv |=> track_hold_q ##63 track_hold_q ##1 !track_hold_q)
      else $error("falling edge did not hold for one conversion");

   a_short_pulse_flag: assert property (
      rise ##1 (!fall)[*8] ##2 start_conv |=> short_q)
      else $error("short convert-start pulse not flagged");

   a_mode_reference: assert property (
      $past(ctrl_q[`ACAP_CTRL_MODE]) |-> ref_pin_q && !mux_select_q)
      else $error("single-channel mode does not use the reference pin");

   a_supply_reference: assert property (
      !$past(ctrl_q[`ACAP_CTRL_MODE]) |-> ref_supply_q && !ref_pin_q)
      else $error("dual-channel mode does not use the supply reference");

   a_alert_on_range: assert property (
      conv_done && range_bad && ctrl_q[`ACAP_CTRL_ALERT_EN] && !ctrl_q[`ACAP_CTRL_BUSY_SEL] |=> alert_busy_oe)
      else $error("out-of-range result did not raise the alert");

   a_busy_span: assert property (
      s_conv_begin ##1 ctrl_q[`ACAP_CTRL_BUSY_SEL] |-> alert_busy_oe && track_hold_q)
      else $error("busy not active during conversion");

   a_busy_release: assert property (
      s_conv_end |=> !alert_busy_oe && result_valid_q && !power_on_q)
      else $error("busy release not aligned with result");

   a_power_down: assert property (
      conv_done |=> (state_q == ACAP_DOWN) && !power_on_q && !track_hold_q)
      else $error("converter did not power down after conversion");

   a_address_float: assert property (
      !addr_taken_q && address_select_float |=> bus_address_q == `ACAP_ADDR_FLOAT)
      else $error("floating address select gave the wrong address");

endmodule // acap_top

//--- core/acap_defines.svh
// Register offsets, field positions, reset values and timing counts of the convert-start and alert block.
`ifndef ACAP_DEFINES_SVH
`define ACAP_DEFINES_SVH

`define ACAP_OFF_CTRL        8'h00
`define ACAP_OFF_LIMITS      8'h04
`define ACAP_OFF_RESULT      8'h08
`define ACAP_OFF_STATUS      8'h0c
`define ACAP_OFF_INT_STATUS  8'h10
`define ACAP_OFF_INT_MASK    8'h14

`define ACAP_CTRL_MODE       0
`define ACAP_CTRL_CHAN       1
`define ACAP_CTRL_BUSY_SEL   2
`define ACAP_CTRL_ALERT_EN   3
`define ACAP_CTRL_RESET      4'h0

`define ACAP_LIM_LOW_LSB     0
`define ACAP_LIM_HIGH_LSB    16
`define ACAP_LIM_LOW_RESET   12'h000
`define ACAP_LIM_HIGH_RESET  12'hfff

`define ACAP_INT_DONE        0
`define ACAP_INT_ALERT       1
`define ACAP_INT_SHORT       2

`define ACAP_ADDR_FLOAT      7'h20
`define ACAP_ADDR_LOW        7'h21
`define ACAP_ADDR_HIGH       7'h22

`define ACAP_CLK_PERIOD_NS   25
`define ACAP_POWERUP_NS      1000
`define ACAP_POWERUP_CYCLES  8'((`ACAP_POWERUP_NS + `ACAP_CLK_PERIOD_NS - 1) / `ACAP_CLK_PERIOD_NS)
`define ACAP_CONV_CYCLES     8'h40

`endif

//--- core/acap_pkg.sv
// Types and helper functions of the convert-start and alert block.
package acap_pkg;

   typedef enum logic [1:0] {
      ACAP_DOWN = 2'b00,
      ACAP_WAKE = 2'b01,
      ACAP_CONV = 2'b10
   } acap_state_type;

   function automatic logic acap_out_of_range(input logic [11:0] value,
                                              input logic [11:0] low,
                                              input logic [11:0] high);
      return (value < low) || (value > high);
   endfunction

   function automatic logic [2:0] acap_w1c(input logic [2:0] cur,
                                           input logic [2:0] set,
                                           input logic [2:0] clr);
      return (cur & ~clr) | set;
   endfunction

endpackage

//--- core/acap_edge.sv
// Rising and falling edge detector for a synchronous pin.
`timescale 1ns/1ps
module acap_edge (
   input  wire logic ref_clk,
   input  wire logic rstn,
   input  wire logic level_i,
   output logic      rise_o,
   output logic      fall_o
);
   logic prev_q;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= level_i;
      end
   end

   assign rise_o = level_i & ~prev_q;
   assign fall_o = ~level_i & prev_q;
endmodule // acap_edge

//--- core/acap_timer.sv
// Loadable down counter that flags its last running cycle.
`timescale 1ns/1ps
module acap_timer (
   input  wire logic       ref_clk,
   input  wire logic       rstn,
   input  wire logic       load_i,
   input  wire logic [7:0] value_i,
   output logic            last_o
);
   logic [7:0] count_q;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         count_q <= 8'h00;
      end else if (load_i) begin
         count_q <= value_i;
      end else if (count_q != 8'h00) begin
         count_q <= count_q - 8'h01;
      end
   end

   assign last_o = (count_q == 8'h01) && !load_i;
endmodule // acap_timer

//--- bench/acap_host_model.sv
// Host-side model that drives convert start and resolves the open-drain alert/busy wire.
`timescale 1ns/1ps
module acap_host_model (
   input  wire logic ref_clk,
   input  wire logic alert_busy_o,
   input  wire logic alert_busy_oe,
   output logic      convert_start_pin,
   output logic      alert_wire
);
   initial begin
      convert_start_pin = 1'b0;
   end

   // Only the pull-up makes the high level; the device can only pull the wire low.
   assign alert_wire = alert_busy_oe ? alert_busy_o : 1'b1;

   // A high time below the power-up window is asked for on purpose to get a flagged result.
   task automatic pulse(input int unsigned high_cycles);
      @(posedge ref_clk);
      convert_start_pin <= 1'b1;
      repeat (high_cycles) @(posedge ref_clk);
      convert_start_pin <= 1'b0;
   endtask
endmodule // acap_host_model

//--- bench/tb.sv
// Self-checking testbench of the convert-start, alert/busy and address-select block.
`timescale 1ns/1ps
`include "acap_defines.svh"
module tb;
   import acap_pkg::*;
   logic        ref_clk, rstn, hsel, hwrite, as_pin, as_float;
   logic [31:0] haddr, hwdata, hrdata, rdv;
   logic [1:0]  htrans;
   logic [11:0] conv_data;
   logic        hreadyout, hresp, power_on, track_hold, mux_select, ref_sup, ref_pin;
   logic        ab_o, ab_oe, ab_wire, cs_pin, irq;
   logic [6:0]  bus_address;
   int          miscompares, check_count, ht, oc, i;
   logic [11:0] vals [4] = '{12'h0ff, 12'h100, 12'h200, 12'h201};
   logic        oor  [4] = '{1'b1, 1'b0, 1'b0, 1'b1};

   acap_top DUT (.ref_clk(ref_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .convert_start_pin(cs_pin), .address_select_pin(as_pin),
      .address_select_float(as_float), .conv_data(conv_data), .power_on(power_on),
      .track_hold(track_hold), .mux_select(mux_select), .ref_from_supply(ref_sup),
      .ref_pin_is_reference(ref_pin), .alert_busy_i(ab_wire), .alert_busy_o(ab_o),
      .alert_busy_oe(ab_oe), .bus_address(bus_address), .irq(irq));

   acap_host_model u_host (.ref_clk(ref_clk), .alert_busy_o(ab_o), .alert_busy_oe(ab_oe),
      .convert_start_pin(cs_pin), .alert_wire(ab_wire));

   initial begin
      ref_clk = 1'b0;
   end
   always #12.5 ref_clk = ~ref_clk;

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge ref_clk);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= wr;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      rdv = hrdata;
   endtask

   task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
      ahb(1'b0, a, 32'h0);
      chk(name, exp, rdv);
      chk("hresp", 32'h0, 32'(hresp));
   endtask

   task automatic do_reset();
      rstn <= 1'b0;
      repeat (8) @(posedge ref_clk);
      rstn <= 1'b1;
      repeat (2) @(posedge ref_clk);
   endtask

   // Counts the cycles of hold and of a low alert wire over one whole conversion.
   task automatic convert(input int unsigned high);
      int n;
      ht = 0;
      oc = 0;
      chk("power_idle", 32'h0, 32'(power_on));
      u_host.pulse(high);
      #1 chk("power_up", 32'h1, 32'(power_on));
      for (n = 0; n < 200 && !(ht > 0 && track_hold === 1'b0); n++) begin
         @(posedge ref_clk);
         #1;
         if (track_hold === 1'b1) ht++;
         if (ab_wire === 1'b0) oc++;
      end
      chk("hold_cycles", `ACAP_CONV_CYCLES, ht);
      chk("power_after", 32'h0, 32'(power_on));
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      #400000;
      miscompares++;
      tally_and_finish();
   end

   initial begin
      miscompares = 0;
      check_count = 0;
      rstn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hwdata = 32'h0;
      as_pin = 1'b0;
      as_float = 1'b1;
      conv_data = 12'h000;
      do_reset();
      chk("addr_float", 32'h20, 32'(bus_address));
      chk("ref_supply", 32'h1, 32'(ref_sup));
      chk("ref_pin", 32'h0, 32'(ref_pin));
      chk("irq_reset", 32'h0, 32'(irq));
      rd("ctrl_reset", `ACAP_OFF_CTRL, 32'h0);
      rd("status_idle", `ACAP_OFF_STATUS, 32'h00000a00);
      rd("limits_reset", `ACAP_OFF_LIMITS, 32'h0fff0000);
      ahb(1'b1, 8'h18, 32'hffffffff);
      rd("unmapped", 8'h18, 32'h0);
      $display("test reset done");

      // Busy mode, dual channel: the wire is low exactly while converting.
      ahb(1'b1, `ACAP_OFF_CTRL, 32'h4);
      conv_data <= 12'habc;
      convert(45);
      chk("busy_cycles", `ACAP_CONV_CYCLES, oc);
      chk("busy_release", 32'h1, 32'(ab_wire));
      rd("result_dual", `ACAP_OFF_RESULT, 32'h00002abc);
      rd("int_done", `ACAP_OFF_INT_STATUS, 32'h1);
      chk("irq_masked", 32'h0, 32'(irq));
      $display("test busy done");

      // Second channel with a too short high time: result flagged bad.
      ahb(1'b1, `ACAP_OFF_CTRL, 32'h6);
      repeat (2) @(posedge ref_clk);
      chk("mux_second", 32'h1, 32'(mux_select));
      conv_data <= 12'h123;
      convert(10);
      rd("result_short", `ACAP_OFF_RESULT, 32'h00007123);
      rd("int_short", `ACAP_OFF_INT_STATUS, 32'h5);
      ahb(1'b1, `ACAP_OFF_INT_MASK, 32'h4);
      repeat (2) @(posedge ref_clk);
      chk("irq_set", 32'h1, 32'(irq));
      ahb(1'b1, `ACAP_OFF_INT_STATUS, 32'h7);
      repeat (2) @(posedge ref_clk);
      chk("irq_clear", 32'h0, 32'(irq));
      rd("int_cleared", `ACAP_OFF_INT_STATUS, 32'h0);
      $display("test short done");

      // Single channel, alert enabled: limit boundaries decide the alert.
      ahb(1'b1, `ACAP_OFF_CTRL, 32'h9);
      ahb(1'b1, `ACAP_OFF_LIMITS, 32'h02000100);
      repeat (2) @(posedge ref_clk);
      chk("ref_pin_single", 32'h1, 32'(ref_pin));
      chk("ref_sup_single", 32'h0, 32'(ref_sup));
      chk("mux_single", 32'h0, 32'(mux_select));
      for (i = 0; i < 4; i++) begin
         conv_data <= vals[i];
         convert(45);
         chk("alert_wire", 32'(!oor[i]), 32'(ab_wire));
         rd("int_alert", `ACAP_OFF_INT_STATUS, {30'h0, oor[i], 1'b1});
         ahb(1'b1, `ACAP_OFF_INT_STATUS, 32'h7);
      end
      // Alert disabled: an out-of-range result must leave the wire released.
      ahb(1'b1, `ACAP_OFF_CTRL, 32'h3);
      repeat (2) @(posedge ref_clk);
      chk("mux_single_chan", 32'h0, 32'(mux_select));
      conv_data <= 12'hfff;
      convert(45);
      chk("alert_off", 32'h1, 32'(ab_wire));
      rd("result_single", `ACAP_OFF_RESULT, 32'h00002fff);
      $display("test alert done");

      // Strap low and high, each taken after its own reset.
      for (i = 0; i < 2; i++) begin
         as_float <= 1'b0;
         as_pin <= i[0];
         do_reset();
         chk("addr_strap", 32'(`ACAP_ADDR_LOW + i), 32'(bus_address));
      end
      $display("test strap done");
      tally_and_finish();
   end
endmodule // tb
